// >>> cis_top.sv
// Comparator input select registers on the special-function-register bus
// Notes on behaviour
// - Zero select register at 0x9f page 0, negative 7:4, positive 3:0, resets 0xff.
// - One select register at 0x9e page 0, same layout, read/write, resets 0xff.
// - Zero negative codes pick port pins, compare, half battery, digital supply, ground.
// - Zero positive codes pick port pins, compare, half battery; 1110 and 1111 battery.
// - One negative select decodes exactly like the zero negative select.
`timescale 1ns/1ps
module cis_top (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic [cis_pkg::NEG_W-1:0] cmp_zero_negative_select_out,
  output logic [cis_pkg::POS_W-1:0] cmp_zero_positive_select_out,
  output logic [cis_pkg::NEG_W-1:0] cmp_one_negative_select_out,
  output logic [cis_pkg::POS_W-1:0] cmp_one_positive_select_out
);
  typedef struct packed {
    logic [7:0] zero_sel;
    logic [7:0] one_sel;
    logic [7:0] rdata;
    logic [cis_pkg::NEG_W-1:0] neg0;
    logic [cis_pkg::POS_W-1:0] pos0;
    logic [cis_pkg::NEG_W-1:0] neg1;
    logic [cis_pkg::POS_W-1:0] pos1;
    logic init_done;
  } cis_state_type;

  localparam cis_state_type STATE_RESET = '{
    zero_sel: cis_pkg::SEL_RESET,
    one_sel: cis_pkg::SEL_RESET,
    rdata: cis_pkg::RDATA_RESET,
    neg0: '0,
    pos0: '0,
    neg1: '0,
    pos1: '0,
    init_done: 1'b0
  };

  logic [1:0] rst_sync;
  logic rst_b;
  cis_state_type state;
  cis_state_type next_state;
  logic init_done;
  logic hit_zero;
  logic hit_one;
  logic [7:0] next_sel [2];
  logic [cis_pkg::NEG_W-1:0] dec_neg [2];
  logic [cis_pkg::POS_W-1:0] dec_pos [2];

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  // Page-zero address match, shared by both registers and both strobes
  function automatic logic sel_hit(input logic [7:0] page, input logic [7:0] addr,
                                   input logic [7:0] target);
    return (page == cis_pkg::SFR_PAGE_ZERO) && (addr == target);
  endfunction

  assign hit_zero = sel_hit(sfr_page_in, sfr_addr_in, cis_pkg::ADDR_ZERO_SEL);
  assign hit_one = sel_hit(sfr_page_in, sfr_addr_in, cis_pkg::ADDR_ONE_SEL);

  // Register value after this edge; decoded ahead so controls load with it
  assign next_sel[0] = (sfr_wr_in && hit_zero) ? sfr_wdata_in : state.zero_sel;
  assign next_sel[1] = (sfr_wr_in && hit_one) ? sfr_wdata_in : state.one_sel;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_dec
      cis_decode #(.TOP_CODE_CONVERTER(i == 1)) u_dec (
        .sel_in(next_sel[i]),
        .neg_out(dec_neg[i]),
        .pos_out(dec_pos[i])
      );
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.init_done = 1'b1;
    next_state.zero_sel = next_sel[0];
    next_state.one_sel = next_sel[1];
    if (sfr_rd_in && hit_zero) begin
      next_state.rdata = state.zero_sel;
    end else if (sfr_rd_in && hit_one) begin
      next_state.rdata = state.one_sel;
    end else if (sfr_rd_in) begin
      next_state.rdata = cis_pkg::RDATA_RESET;
    end
    // Controls registered on the same edge as the register value
    next_state.neg0 = dec_neg[0];
    next_state.pos0 = dec_pos[0];
    next_state.neg1 = dec_neg[1];
    next_state.pos1 = dec_pos[1];
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata_out = state.rdata;
  assign cmp_zero_negative_select_out = state.neg0;
  assign cmp_zero_positive_select_out = state.pos0;
  assign cmp_one_negative_select_out = state.neg1;
  assign cmp_one_positive_select_out = state.pos1;
  assign init_done = state.init_done;

  AST_ZERO_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_wr_in && hit_zero) |=> (state.zero_sel == $past(sfr_wdata_in)))
    else $error("zero select register did not take the write");

  AST_ONE_WRITE_AND_READ: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_wr_in && hit_one) ##1 (sfr_rd_in && hit_one && !sfr_wr_in)
      |=> (sfr_rdata_out == $past(sfr_wdata_in, 2)))
    else $error("one select register did not read back the written value");

  AST_ZERO_NEG_GROUND: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.zero_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO] == cis_pkg::CODE_F)
      |-> (cmp_zero_negative_select_out == (11'h001 << cis_pkg::NEG_GROUND)))
    else $error("zero negative code 1111 did not select ground");

  AST_ZERO_POS_BATTERY: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.zero_sel[cis_pkg::POS_HI:cis_pkg::POS_LO] >= cis_pkg::CODE_E)
      |-> (cmp_zero_positive_select_out == (12'h001 << cis_pkg::POS_BATTERY)))
    else $error("zero positive top codes did not select battery");

  AST_ONE_NEG_MATCHES_ZERO: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.one_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO]
      == state.zero_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO])
      |-> (cmp_one_negative_select_out == cmp_zero_negative_select_out))
    else $error("one negative decode differs from zero negative decode");

  AST_ONE_POS_CONVERTER: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.one_sel[cis_pkg::POS_HI:cis_pkg::POS_LO] == cis_pkg::CODE_F)
      |-> (cmp_one_positive_select_out == (12'h001 << cis_pkg::POS_CONVERTER)))
    else $error("one positive code 1111 did not select converter supply");

  AST_WRITE_EDGE_CONTROL: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_wr_in && hit_zero && sfr_wdata_in[cis_pkg::NEG_HI:cis_pkg::NEG_LO] == cis_pkg::CODE_0)
      |=> (cmp_zero_negative_select_out == (11'h001 << cis_pkg::NEG_P0_1)))
    else $error("negative control did not follow the write on its edge");

  AST_RESERVED_NONE: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.zero_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO] == cis_pkg::CODE_3)
      |-> (cmp_zero_negative_select_out == '0))
    else $error("reserved negative code drove a selection");

  AST_ZERO_RESET: assert property (@(posedge clk_in) disable iff (!rst_b)
    !init_done |-> (state.zero_sel == cis_pkg::SEL_RESET))
    else $error("zero select register did not leave reset at all ones");

  AST_ONE_RESET: assert property (@(posedge clk_in) disable iff (!rst_b)
    !init_done |-> (state.one_sel == cis_pkg::SEL_RESET))
    else $error("one select register did not leave reset at all ones");

  AST_ONE_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_wr_in && hit_one) |=> (state.one_sel == $past(sfr_wdata_in)))
    else $error("one select register did not take the write");

  AST_ZERO_READ: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_rd_in && hit_zero) |=> (sfr_rdata_out == $past(state.zero_sel)))
    else $error("zero select register read returned the wrong value");

  AST_ONE_READ: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_rd_in && hit_one) |=> (sfr_rdata_out == $past(state.one_sel)))
    else $error("one select register read returned the wrong value");

  AST_FOREIGN_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_wr_in && !hit_zero && !hit_one)
      |=> ($stable(state.zero_sel) && $stable(state.one_sel)))
    else $error("write to another address changed a select register");

  AST_FOREIGN_READ: assert property (@(posedge clk_in) disable iff (!rst_b)
    (sfr_rd_in && !hit_zero && !hit_one) |=> (sfr_rdata_out == cis_pkg::RDATA_RESET))
    else $error("read of another address did not return zero");

  AST_RDATA_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b)
    !sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");

  AST_ZERO_NEG_COMPARE: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.zero_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO] == cis_pkg::CODE_COMPARE)
      |-> (cmp_zero_negative_select_out == (11'h001 << cis_pkg::NEG_COMPARE)))
    else $error("zero negative compare code did not select compare");

  AST_ZERO_POS_NO_CONVERTER: assert property (@(posedge clk_in) disable iff (!rst_b)
    !cmp_zero_positive_select_out[cis_pkg::POS_CONVERTER])
    else $error("zero positive control selected the converter supply");

  AST_ONE_POS_BATTERY: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.one_sel[cis_pkg::POS_HI:cis_pkg::POS_LO] == cis_pkg::CODE_E)
      |-> (cmp_one_positive_select_out == (12'h001 << cis_pkg::POS_BATTERY)))
    else $error("one positive code 1110 did not select battery");

  AST_ONE_NEG_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_b)
    (init_done && state.one_sel[cis_pkg::NEG_HI:cis_pkg::NEG_LO] == cis_pkg::CODE_3)
      |-> (cmp_one_negative_select_out == '0))
    else $error("reserved one negative code drove a selection");

  AST_CONTROLS_ONEHOT: assert property (@(posedge clk_in) disable iff (!rst_b)
    $onehot0(cmp_zero_negative_select_out) && $onehot0(cmp_zero_positive_select_out)
      && $onehot0(cmp_one_negative_select_out) && $onehot0(cmp_one_positive_select_out))
    else $error("a multiplexer control selected more than one source");
endmodule

// >>> cis_pkg.sv
// Constants for the comparator input select register bank
package cis_pkg;
  localparam logic [7:0] ADDR_ONE_SEL = 8'h9e;
  localparam logic [7:0] ADDR_ZERO_SEL = 8'h9f;
  localparam logic [7:0] SFR_PAGE_ZERO = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'hff;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam int NEG_HI = 7;
  localparam int NEG_LO = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;
  localparam int NEG_W = 11;
  localparam int POS_W = 12;
  // Select codes
  localparam logic [3:0] CODE_0 = 4'h0;
  localparam logic [3:0] CODE_1 = 4'h1;
  localparam logic [3:0] CODE_2 = 4'h2;
  localparam logic [3:0] CODE_3 = 4'h3;
  localparam logic [3:0] CODE_6 = 4'h6;
  localparam logic [3:0] CODE_7 = 4'h7;
  localparam logic [3:0] CODE_8 = 4'h8;
  localparam logic [3:0] CODE_9 = 4'h9;
  localparam logic [3:0] CODE_COMPARE = 4'hc;
  localparam logic [3:0] CODE_HALF_BATT = 4'hd;
  localparam logic [3:0] CODE_E = 4'he;
  localparam logic [3:0] CODE_F = 4'hf;
  // Negative multiplexer one-hot bit positions
  localparam int NEG_P0_1 = 0;
  localparam int NEG_P0_3 = 1;
  localparam int NEG_P0_5 = 2;
  localparam int NEG_P1_5 = 3;
  localparam int NEG_P1_7 = 4;
  localparam int NEG_P2_1 = 5;
  localparam int NEG_P2_3 = 6;
  localparam int NEG_COMPARE = 7;
  localparam int NEG_HALF_BATT = 8;
  localparam int NEG_DIGITAL = 9;
  localparam int NEG_GROUND = 10;
  // Positive multiplexer one-hot bit positions
  localparam int POS_P0_0 = 0;
  localparam int POS_P0_2 = 1;
  localparam int POS_P0_4 = 2;
  localparam int POS_P0_6 = 3;
  localparam int POS_P1_4 = 4;
  localparam int POS_P1_6 = 5;
  localparam int POS_P2_0 = 6;
  localparam int POS_P2_2 = 7;
  localparam int POS_COMPARE = 8;
  localparam int POS_HALF_BATT = 9;
  localparam int POS_BATTERY = 10;
  localparam int POS_CONVERTER = 11;
endpackage

// >>> cis_decode.sv
// Decodes one select register into one-hot multiplexer controls
`timescale 1ns/1ps
module cis_decode #(
  parameter bit TOP_CODE_CONVERTER = 1'b0
) (
  input wire logic [7:0] sel_in,
  output logic [cis_pkg::NEG_W-1:0] neg_out,
  output logic [cis_pkg::POS_W-1:0] pos_out
);
  function automatic logic [cis_pkg::NEG_W-1:0] decode_neg(input logic [3:0] code);
    logic [cis_pkg::NEG_W-1:0] v;
    v = '0;
    case (code)
      cis_pkg::CODE_0: v[cis_pkg::NEG_P0_1] = 1'b1;
      cis_pkg::CODE_1: v[cis_pkg::NEG_P0_3] = 1'b1;
      cis_pkg::CODE_2: v[cis_pkg::NEG_P0_5] = 1'b1;
      cis_pkg::CODE_6: v[cis_pkg::NEG_P1_5] = 1'b1;
      cis_pkg::CODE_7: v[cis_pkg::NEG_P1_7] = 1'b1;
      cis_pkg::CODE_8: v[cis_pkg::NEG_P2_1] = 1'b1;
      cis_pkg::CODE_9: v[cis_pkg::NEG_P2_3] = 1'b1;
      cis_pkg::CODE_COMPARE: v[cis_pkg::NEG_COMPARE] = 1'b1;
      cis_pkg::CODE_HALF_BATT: v[cis_pkg::NEG_HALF_BATT] = 1'b1;
      cis_pkg::CODE_E: v[cis_pkg::NEG_DIGITAL] = 1'b1;
      cis_pkg::CODE_F: v[cis_pkg::NEG_GROUND] = 1'b1;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic [cis_pkg::POS_W-1:0] decode_pos(input logic [3:0] code,
                                                           input logic conv);
    logic [cis_pkg::POS_W-1:0] v;
    v = '0;
    case (code)
      cis_pkg::CODE_0: v[cis_pkg::POS_P0_0] = 1'b1;
      cis_pkg::CODE_1: v[cis_pkg::POS_P0_2] = 1'b1;
      cis_pkg::CODE_2: v[cis_pkg::POS_P0_4] = 1'b1;
      cis_pkg::CODE_3: v[cis_pkg::POS_P0_6] = 1'b1;
      cis_pkg::CODE_6: v[cis_pkg::POS_P1_4] = 1'b1;
      cis_pkg::CODE_7: v[cis_pkg::POS_P1_6] = 1'b1;
      cis_pkg::CODE_8: v[cis_pkg::POS_P2_0] = 1'b1;
      cis_pkg::CODE_9: v[cis_pkg::POS_P2_2] = 1'b1;
      cis_pkg::CODE_COMPARE: v[cis_pkg::POS_COMPARE] = 1'b1;
      cis_pkg::CODE_HALF_BATT: v[cis_pkg::POS_HALF_BATT] = 1'b1;
      cis_pkg::CODE_E: v[cis_pkg::POS_BATTERY] = 1'b1;
      cis_pkg::CODE_F: begin
        if (conv) begin
          v[cis_pkg::POS_CONVERTER] = 1'b1;
        end else begin
          v[cis_pkg::POS_BATTERY] = 1'b1;
        end
      end
      default: v = '0;
    endcase
    return v;
  endfunction

  assign neg_out = decode_neg(sel_in[cis_pkg::NEG_HI:cis_pkg::NEG_LO]);
  assign pos_out = decode_pos(sel_in[cis_pkg::POS_HI:cis_pkg::POS_LO], TOP_CODE_CONVERTER);
endmodule

// >>> cis_core_model.sv
// Processor core model issuing special-function-register cycles
`timescale 1ns/1ps
module cis_core_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] page_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial begin
    {addr_out, page_out, wr_out, rd_out, wdata_out} = '0;
  end
  // Called at a falling edge; request held over one rising edge
  task automatic xfer(input logic w, input logic r, input logic [7:0] p,
                      input logic [7:0] a, input logic [7:0] d);
    wr_out = w;
    rd_out = r;
    page_out = p;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
  endtask
  // Released address and data show the inverse of the last value; page is held
  task automatic idle();
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
    @(negedge clk_in);
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the comparator input select registers
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr, page, wdata, rdata;
  logic wr, rd;
  logic [cis_pkg::NEG_W-1:0] neg0, neg1;
  logic [cis_pkg::POS_W-1:0] pos0, pos1;
  logic [7:0] shadow [2];
  logic [31:0] r;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  cis_core_model i_core (.clk_in(clk_in), .addr_out(addr), .page_out(page), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));
  cis_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(addr),
    .sfr_page_in(page), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .cmp_zero_negative_select_out(neg0),
    .cmp_zero_positive_select_out(pos0), .cmp_one_negative_select_out(neg1),
    .cmp_one_positive_select_out(pos1));
  function automatic logic [11:0] exp_sel(input logic [3:0] c, input bit pos, input bit one);
    int i;
    case (c)
      4'h0, 4'h1, 4'h2: i = c;
      4'h3: i = pos ? 3 : -1;
      4'h6, 4'h7, 4'h8, 4'h9: i = c - (pos ? 2 : 3);
      4'hc, 4'hd, 4'he: i = c - (pos ? 4 : 5);
      4'hf: i = (pos && one) ? 11 : 10;
      default: i = -1;
    endcase
    return (i < 0) ? 12'h000 : (12'h001 << i);
  endfunction
  function automatic logic [7:0] legal_sel(input logic [7:0] d);
    logic [15:0] rsv;
    logic [3:0] n;
    logic [3:0] p;
    rsv = 16'h0c30;
    p = rsv[d[3:0]] ? 4'hd : d[3:0];
    rsv[3] = 1'b1;
    n = rsv[d[7:4]] ? 4'hc : d[7:4];
    return {n, p};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] p, input logic [7:0] a);
    if (p != cis_pkg::SFR_PAGE_ZERO) return 8'h00;
    if (a == cis_pkg::ADDR_ZERO_SEL) return shadow[0];
    return (a == cis_pkg::ADDR_ONE_SEL) ? shadow[1] : 8'h00;
  endfunction
  task automatic chk_sel(input string n, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH read data exp %h got %h", e, g);
    end
  endtask
  task automatic chk_all();
    chk_sel("zero neg", exp_sel(shadow[0][7:4], 0, 0), {1'b0, neg0});
    chk_sel("zero pos", exp_sel(shadow[0][3:0], 1, 0), pos0);
    chk_sel("one neg", exp_sel(shadow[1][7:4], 0, 1), {1'b0, neg1});
    chk_sel("one pos", exp_sel(shadow[1][3:0], 1, 1), pos1);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    i_core.xfer(1'b1, 1'b0, p, a, d);
    if (p == 8'h00 && a[7:1] == 7'h4f) shadow[~a[0]] = d;
    chk_all();
  endtask
  task automatic rd_reg(input logic [7:0] p, input logic [7:0] a);
    i_core.xfer(1'b0, 1'b1, p, a, 8'h00);
    chk_rd(exp_rd(p, a), rdata);
  endtask
  task automatic reset_dut();
    rst_b_in = 1'b0;
    @(negedge clk_in);
    chk_sel("reset sel", 12'h000, {1'b0, neg0 | neg1} | pos0 | pos1);
    chk_rd(8'h00, rdata);
    repeat (19) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    shadow[0] = cis_pkg::SEL_RESET;
    shadow[1] = cis_pkg::SEL_RESET;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h9766));
    reset_dut();
    chk_all();
    rd_reg(8'h00, 8'h9f);
    rd_reg(8'h00, 8'h9e);
    $display("test reset done");
    // Reserved codes included on purpose to see them select nothing
    for (int c = 0; c < 16; c++) begin
      wr_reg(8'h00, 8'h9f, {c[3:0], ~c[3:0]});
      wr_reg(8'h00, 8'h9e, {~c[3:0], c[3:0]});
      rd_reg(8'h00, 8'h9f);
      rd_reg(8'h00, 8'h9e);
    end
    i_core.idle();
    $display("test codes done");
    wr_reg(8'h01, 8'h9f, 8'h00);
    wr_reg(8'h00, 8'h9d, 8'h00);
    rd_reg(8'h01, 8'h9e);
    i_core.xfer(1'b1, 1'b1, 8'h00, 8'h9f, 8'h6c);
    chk_rd(shadow[0], rdata);
    shadow[0] = 8'h6c;
    chk_all();
    $display("test refusals done");
    repeat (60) begin
      r = $urandom;
      addr_pick: begin
        logic [7:0] a;
        logic [7:0] p;
        a = (r[9:8] == 2'b00) ? r[7:0] : {7'h4f, r[8]};
        p = (r[12:11] == 2'b00) ? r[31:24] : 8'h00;
        if (r[10]) wr_reg(p, a, legal_sel(r[23:16]));
        rd_reg(p, a);
      end
    end
    i_core.idle();
    $display("test random done");
    reset_dut();
    chk_all();
    $display("test second reset done");
    stop_test();
  end
endmodule
